/* File: design/fsksl_bitsync.sv */
// Purpose: bit clock recovery and majority decision per bit
// Assumes: sample_en_i at the decimated rate, period of at least two
// Notes: an input edge restarts the bit window
`timescale 1ns/100ps
module fsksl_bitsync #(
    parameter int PW = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // oversampled comparator
    input wire logic sample_en_i,
    input wire logic above_i,
    input wire logic [PW-1:0] period_i,
    // decided bit
    output logic bit_o,
    output logic bit_valid_o
);
    if (PW < 2) begin : g_bad_pw
        $error("fsksl_bitsync: PW below 2");
    end

    logic [PW-1:0] phase;
    logic [PW-1:0] ones;
    logic prev_above;

    wire [PW-1:0] half = period_i >> 1;
    wire [PW-1:0] ones_next = ones + {{(PW-1){1'b0}}, above_i};
    wire edge_seen = sample_en_i && (above_i != prev_above);
    wire at_last = (phase >= period_i - {{(PW-1){1'b0}}, 1'b1});
    // late edge closes the current bit early instead of dropping it
    wire late_edge = edge_seen && (phase >= half);
    wire decide_full = sample_en_i && at_last && !edge_seen;
    wire decide_late = sample_en_i && late_edge;
    wire [PW:0] ones_x2 = {ones, 1'b0};
    wire [PW:0] full_x2 = {ones_next, 1'b0};
    wire bit_late = ones_x2 > {1'b0, phase};
    wire bit_full = full_x2 > {1'b0, period_i};

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            phase <= '0;
            ones <= '0;
            prev_above <= 1'b0;
            bit_o <= 1'b0;
            bit_valid_o <= 1'b0;
        end else begin
            bit_valid_o <= decide_full | decide_late; // see (R16)
            if (sample_en_i) begin
                prev_above <= above_i;
                if (edge_seen) begin
                    phase <= {{(PW-1){1'b0}}, 1'b1}; // see (R16)
                    ones <= {{(PW-1){1'b0}}, above_i};
                    if (late_edge) begin
                        bit_o <= bit_late; // see (R17)
                    end
                end else if (at_last) begin
                    phase <= '0;
                    ones <= '0;
                    bit_o <= bit_full; // see (R17)
                end else begin
                    phase <= phase + {{(PW-1){1'b0}}, 1'b1};
                    ones <= ones_next;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_full_window;
        sample_en_i && at_last && !edge_seen && (ones_next == period_i)
            |=> bit_valid_o && bit_o;
    endproperty
    a_full_window: assert property (p_full_window) else $error("steady ones not decided as one"); // see (R16)
endmodule

/* File: design/fsksl_pkg.sv */
// Purpose: constants, types and helpers for the fsk receive slicer
// Assumes: one 100 MHz core clock, registers over Avalon-MM
// Notes: samples are signed offsets from the nominal IF
// Summary of operation
// (R1) IF rate is crystal clock over eight times (ADC divider plus one).
// (R2) filter skip bit set routes samples around the fixed analog filter.
// (R3) IF rate always equals ADC sample rate divided by four.
// (R4) channel bandwidth is programmable from 9.6 up to 307.2 kHz.
// (R5) bandwidth is 307.2 kHz over (decimation divider plus one).
// (R6) software picks divider codes from the bandwidth table, 11000b to 00000b.
// (R7) slicing level is the mean of detected minimum and maximum deviation.
// (R8) expected deviation comes from two-bit exponent and four-bit mantissa.
// (R9) a shift beyond expected deviation records a transition and recomputes level.
// (R10) at least three recorded transitions before a computed slicing level.
// (R11) averaging length field lengthens averaging of the extremes.
// (R12) averaging length 00 disables estimation; slice symmetrically around IF. The code still learns the extremes and reports avg_freq_o.
// (R13) with data present the estimate is usable after three transitions.
// (R14) computed average frequency is exported as a frequency offset measure.
// (R15) transmitter sends alternating 0101 preamble so the bit clock can lock.
// (R16) bit synchroniser aligns to data, deciding by oversampling and filtering.
// (R17) bit is one when frequency lies above the slicing level.
package fsksl_pkg;
    localparam int FW = 16;
    localparam int AW = 4;
    localparam int DEC_W = 5;
    localparam int SPB_W = 8;
    localparam int ACC_W = FW + DEC_W;
    localparam int RECIP_SHIFT = 16;
    localparam int DEV_BASE_SHIFT = 4;

    localparam logic [AW-1:0] ADDR_CONFIG_A = 4'h0;
    localparam logic [AW-1:0] ADDR_FREQ_CORR = 4'h4;
    localparam logic [AW-1:0] ADDR_STATUS = 4'h8;
    localparam logic [AW-1:0] ADDR_AVG_FREQ = 4'hC;

    localparam logic [31:0] CFG_MASK = 32'h00FF_01FF;
    localparam logic [31:0] CFG_RESET = 32'h0008_0003;
    localparam logic [31:0] FCC_MASK = 32'h0000_00FF;
    localparam logic [31:0] FCC_RESET = 32'h0000_0050;

    localparam logic [1:0] IF_LAST = 2'h3;
    localparam logic [1:0] MIN_TRANSITIONS = 2'h3;
    localparam logic [1:0] AVG_OFF = 2'h0;
    localparam logic signed [FW-1:0] EXT_INIT = 16'h7FFF;

    typedef struct packed {
        logic [SPB_W-1:0] samples_per_bit;
        logic [6:0] unused_hi;
        logic [DEC_W-1:0] decimation_divider;
        logic filter_skip;
        logic [2:0] adc_div;
    } fsksl_cfg_t;

    typedef struct packed {
        logic [1:0] slicer_average_length;
        logic [3:0] expected_dev_mantissa;
        logic [1:0] expected_dev_exponent;
    } fsksl_fcc_t;

    typedef struct packed {
        logic signed [FW-1:0] level;
        logic last_bit;
        logic slice_valid;
        logic [1:0] transitions;
    } fsksl_status_t;

    function automatic logic [31:0] fsksl_be_merge(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return r;
    endfunction

    // rounded 2^16 / (div + 1), so the boxcar sum becomes a mean
    function automatic logic [RECIP_SHIFT:0] fsksl_recip(input logic [DEC_W-1:0] div);
        int n;
        n = int'(div) + 1;
        return (RECIP_SHIFT+1)'(((1 << RECIP_SHIFT) + n / 2) / n);
    endfunction

    function automatic logic signed [FW-1:0] fsksl_avg_step(input logic signed [FW-1:0] a,
            input logic signed [FW-1:0] b, input logic [1:0] k);
        logic signed [FW:0] d;
        d = {b[FW-1], b} - {a[FW-1], a};
        d = d >>> k;
        return a + d[FW-1:0];
    endfunction
endpackage

/* File: design/fsksl_top.sv */
// Purpose: fsk receive IF chain, channel filter, adaptive slicer, bit output
// Assumes: demodulated frequency samples arrive on the core clock
// Notes: one sample is in flight at a time; bus answers after one wait cycle
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module fsksl_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // register bus
    input wire logic [fsksl_pkg::AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // demodulated frequency stream
    input wire logic signed [fsksl_pkg::FW-1:0] freq_sample_i,
    input wire logic freq_valid_i,
    output logic freq_ready_o,
    // decided bits
    output logic bit_data_o,
    output logic bit_valid_o,
    input wire logic bit_ready_i,
    // status
    output logic filter_skip_o,
    output logic adc_tick_o,
    output logic if_tick_o,
    output logic signed [fsksl_pkg::FW-1:0] avg_freq_o,
    output logic slice_valid_o
);
    import fsksl_pkg::*;

    // register file
    logic [31:0] cfg_word;
    logic [31:0] fcc_word;
    fsksl_cfg_t cfg;
    fsksl_fcc_t fcc;
    fsksl_status_t status;

    // divider and pipeline state
    logic [3:0] adc_cnt;
    logic [1:0] if_cnt;
    logic af_v;
    logic signed [FW-1:0] af_state;
    logic signed [FW-1:0] af_val;
    logic signed [ACC_W-1:0] acc;
    logic [DEC_W-1:0] dcnt;
    logic dec_v;
    logic signed [FW-1:0] dec_val;

    // slicer state
    logic run_hi;
    logic signed [FW-1:0] run_ext;
    logic signed [FW-1:0] min_avg;
    logic signed [FW-1:0] max_avg;
    logic have_min;
    logic have_max;
    logic [1:0] trans;
    logic signed [FW-1:0] level_q;
    logic cmp_v;
    logic cmp_above;

    // bit sync and output buffer
    logic bs_bit;
    logic bs_valid;
    logic spare_d;
    logic spare_v;

    assign cfg = cfg_word[23:0];
    assign fcc = fcc_word[7:0];

    // bus decode
    wire bus_req = avs_read_i | avs_write_i;
    wire bus_acc = bus_req & ~avs_waitrequest_o;
    wire wr_acc = bus_acc & avs_write_i;
    wire wr_cfg = wr_acc && (avs_address_i == ADDR_CONFIG_A);
    wire wr_fcc = wr_acc && (avs_address_i == ADDR_FREQ_CORR);
    // new settings invalidate the learnt extremes and the divider phase
    wire restart = wr_cfg | wr_fcc;
    wire [31:0] avg_word = {16'h0000, avg_freq_o};
    wire [31:0] status_word = {12'h000, status};
    wire [31:0] rd_mux = (avs_address_i == ADDR_CONFIG_A) ? cfg_word :
                         (avs_address_i == ADDR_FREQ_CORR) ? fcc_word :
                         (avs_address_i == ADDR_STATUS) ? status_word :
                         (avs_address_i == ADDR_AVG_FREQ) ? avg_word : 32'h0000_0000;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            cfg_word <= CFG_RESET;
            fcc_word <= FCC_RESET;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (bus_req & avs_waitrequest_o) begin
                avs_readdata_o <= rd_mux;
            end
            if (wr_cfg) begin
                cfg_word <= fsksl_be_merge(cfg_word, avs_writedata_i, avs_byteenable_i) & CFG_MASK;
            end
            if (wr_fcc) begin
                fcc_word <= fsksl_be_merge(fcc_word, avs_writedata_i, avs_byteenable_i) & FCC_MASK;
            end
        end
    end

    // ADC rate is core over 2*(div+1); IF is a quarter of that
    wire [3:0] adc_last = {cfg.adc_div, 1'b1};
    wire adc_wrap = (adc_cnt == adc_last);
    wire if_wrap = adc_wrap && (if_cnt == IF_LAST);

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || restart) begin
            adc_cnt <= 4'h0;
            if_cnt <= 2'h0;
            adc_tick_o <= 1'b0;
            if_tick_o <= 1'b0;
        end else begin
            adc_cnt <= adc_wrap ? 4'h0 : adc_cnt + 4'h1; // see (R1)
            if (adc_wrap) begin
                if_cnt <= if_wrap ? 2'h0 : if_cnt + 2'h1; // see (R3)
            end
            adc_tick_o <= adc_wrap;
            if_tick_o <= if_wrap; // see (R1)
        end
    end

    // input pacing: one sample per ADC tick, only when nothing is in flight
    wire buf_full = bit_valid_o & spare_v;
    wire pipe_busy = af_v | dec_v | cmp_v | bs_valid;
    wire take = freq_valid_i & freq_ready_o;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            freq_ready_o <= 1'b0;
        end else if (take) begin
            freq_ready_o <= 1'b0;
        end else if (adc_wrap && !pipe_busy && !buf_full) begin
            freq_ready_o <= 1'b1;
        end
    end

    // fixed smoothing stage standing in for the analog filter
    wire signed [FW:0] af_diff = {freq_sample_i[FW-1], freq_sample_i} - {af_state[FW-1], af_state};
    wire signed [FW-1:0] af_smooth = af_state + $signed(af_diff[FW:1]);

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            af_v <= 1'b0;
            af_state <= '0;
            af_val <= '0;
            filter_skip_o <= 1'b0;
        end else begin
            af_v <= take;
            filter_skip_o <= cfg.filter_skip; // see (R2)
            if (take) begin
                af_state <= af_smooth;
                af_val <= cfg.filter_skip ? freq_sample_i : af_smooth; // see (R2)
            end
        end
    end

    // boxcar decimator: div+1 samples averaged, bandwidth scales inversely
    wire signed [ACC_W-1:0] acc_next = acc + {{DEC_W{af_val[FW-1]}}, af_val};
    wire dec_wrap = (dcnt == cfg.decimation_divider);
    wire signed [RECIP_SHIFT+1:0] recip = {1'b0, fsksl_recip(cfg.decimation_divider)};
    wire signed [ACC_W+RECIP_SHIFT+1:0] dec_prod = acc_next * recip;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || restart) begin
            acc <= '0;
            dcnt <= '0;
            dec_v <= 1'b0;
            dec_val <= '0;
        end else begin
            dec_v <= af_v & dec_wrap; // see (R5)
            if (af_v) begin
                if (dec_wrap) begin
                    acc <= '0;
                    dcnt <= '0;
                    dec_val <= dec_prod[RECIP_SHIFT +: FW]; // see (R4)
                end else begin
                    acc <= acc_next;
                    dcnt <= dcnt + {{(DEC_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // slicer: extremes of each run, averaged, midpoint is the level
    wire [FW-1:0] dev = {{(FW-4){1'b0}}, fcc.expected_dev_mantissa}
        << (fcc.expected_dev_exponent + DEV_BASE_SHIFT); // see (R8)
    wire signed [FW:0] dev_x = {1'b0, dev};
    wire signed [FW:0] x_x = {dec_val[FW-1], dec_val};
    wire signed [FW:0] e_x = {run_ext[FW-1], run_ext};
    wire signed [FW:0] up_gap = x_x - e_x;
    wire signed [FW:0] dn_gap = e_x - x_x;
    wire went_up = dec_v && !run_hi && (up_gap > dev_x);
    wire went_dn = dec_v && run_hi && (dn_gap > dev_x);
    wire [1:0] avg_len = fcc.slicer_average_length;
    wire [1:0] avg_shift = (avg_len == AVG_OFF) ? 2'h0 : avg_len - 2'h1;
    wire signed [FW-1:0] min_next = have_min ? fsksl_avg_step(min_avg, run_ext, avg_shift) : run_ext;
    wire signed [FW-1:0] max_next = have_max ? fsksl_avg_step(max_avg, run_ext, avg_shift) : run_ext;
    wire signed [FW:0] center_sum = {min_avg[FW-1], min_avg} + {max_avg[FW-1], max_avg};
    wire signed [FW-1:0] center = center_sum[FW:1];
    wire slice_ready = (trans == MIN_TRANSITIONS); // see (R13)
    wire signed [FW-1:0] level = ((avg_len == AVG_OFF) || !slice_ready) ? '0 : center; // see (R12)
    wire above = dec_val > level;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || restart) begin
            run_hi <= 1'b0;
            run_ext <= EXT_INIT;
            min_avg <= '0;
            max_avg <= '0;
            have_min <= 1'b0;
            have_max <= 1'b0;
            trans <= 2'h0;
        end else if (went_up) begin
            min_avg <= min_next; // see (R11)
            have_min <= 1'b1;
            run_hi <= 1'b1;
            run_ext <= dec_val;
            trans <= slice_ready ? trans : trans + 2'h1; // see (R9)
        end else if (went_dn) begin
            max_avg <= max_next; // see (R11)
            have_max <= 1'b1;
            run_hi <= 1'b0;
            run_ext <= dec_val;
            trans <= slice_ready ? trans : trans + 2'h1; // see (R9)
        end else if (dec_v && (run_hi ? dec_val > run_ext : dec_val < run_ext)) begin
            run_ext <= dec_val;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cmp_v <= 1'b0;
            cmp_above <= 1'b0;
            level_q <= '0;
            avg_freq_o <= '0;
            slice_valid_o <= 1'b0;
        end else begin
            cmp_v <= dec_v;
            if (dec_v) begin
                cmp_above <= above; // see (R17)
            end
            level_q <= level; // see (R7)
            avg_freq_o <= center; // see (R14)
            slice_valid_o <= slice_ready; // see (R10)
        end
    end

    assign status = '{level: level_q, last_bit: bs_bit, slice_valid: slice_valid_o,
                      transitions: trans};

    fsksl_bitsync #(
        .PW(SPB_W)
    ) u_bitsync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .sample_en_i(cmp_v),
        .above_i(cmp_above),
        .period_i(cfg.samples_per_bit),
        .bit_o(bs_bit),
        .bit_valid_o(bs_valid)
    );

    // two-entry buffer: output register plus one spare slot
    wire pop = bit_valid_o & bit_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            bit_data_o <= 1'b0;
            bit_valid_o <= 1'b0;
            spare_d <= 1'b0;
            spare_v <= 1'b0;
        end else if (pop || !bit_valid_o) begin
            bit_valid_o <= spare_v | bs_valid;
            bit_data_o <= spare_v ? spare_d : bs_bit;
            spare_v <= spare_v & bs_valid;
            if (bs_valid) begin
                spare_d <= bs_bit;
            end
        end else if (bs_valid) begin
            spare_v <= 1'b1;
            spare_d <= bs_bit;
        end
    end

    // checking helpers
    logic [6:0] if_gap;
    logic if_armed;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || restart) begin
            if_gap <= 7'h00;
            if_armed <= 1'b0;
        end else if (if_tick_o) begin
            if_gap <= 7'h00;
            if_armed <= 1'b1;
        end else begin
            if_gap <= if_gap + 7'h01;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_rise;
        went_up && !restart;
    endsequence

    property p_if_period;
        if_tick_o && if_armed && !restart |-> if_gap == {1'b0, cfg.adc_div, 3'b111};
    endproperty
    a_if_period: assert property (p_if_period) else $error("IF tick spacing wrong"); // see (R1)

    property p_if_on_adc;
        if_tick_o |-> adc_tick_o ##1 !adc_tick_o;
    endproperty
    a_if_on_adc: assert property (p_if_on_adc) else $error("IF tick not on an ADC tick"); // see (R3)

    property p_skip_route;
        take && cfg.filter_skip |=> af_v && (af_val == $past(freq_sample_i));
    endproperty
    a_skip_route: assert property (p_skip_route) else $error("skipped filter altered data"); // see (R2)

    property p_decimate;
        af_v && dec_wrap && !restart |=> dec_v;
    endproperty
    a_decimate: assert property (p_decimate) else $error("decimator missed its output"); // see (R5)

    property p_rise_records;
        s_rise |=> run_hi && have_min && (run_ext == $past(dec_val));
    endproperty
    a_rise_records: assert property (p_rise_records) else $error("transition not recorded"); // see (R9)

    property p_symmetric;
        dec_v && !restart && (avg_len == AVG_OFF) && (dec_val > 0) |=> cmp_v && cmp_above;
    endproperty
    a_symmetric: assert property (p_symmetric) else $error("level not at IF when disabled"); // see (R12)

    property p_too_few;
        dec_v && !restart && !slice_ready && (dec_val <= 0) |=> cmp_v && !cmp_above;
    endproperty
    a_too_few: assert property (p_too_few) else $error("level used before three transitions"); // see (R10)

    property p_level_avg;
        cmp_v && slice_valid_o && (avg_len != AVG_OFF) && !$past(restart)
            |-> cmp_above == (dec_val > avg_freq_o);
    endproperty
    a_level_avg: assert property (p_level_avg) else $error("decision not against average"); // see (R14)
endmodule

/* File: test/fsksl_tx_model.sv */
// Purpose: far-side fsk transmitter feeding demodulated frequency samples
// Assumes: the bench picks symbol, centre and deviation
// Notes: sample line shows the inverted last value while idle
`timescale 1ns/100ps
module fsksl_tx_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // symbol control
    input wire logic sym_i,
    input wire logic signed [fsksl_pkg::FW-1:0] centre_i,
    input wire logic signed [fsksl_pkg::FW-1:0] dev_i,
    // frequency stream
    input wire logic freq_ready_i,
    output logic signed [fsksl_pkg::FW-1:0] freq_sample_o,
    output logic freq_valid_o
);
    import fsksl_pkg::*;
    logic signed [FW-1:0] tone;
    // two tones around an offset centre; bench sends 0101 preamble
    assign tone = sym_i ? centre_i + dev_i : centre_i - dev_i;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            freq_valid_o <= 1'b0;
            freq_sample_o <= 16'h0000;
        end else if (freq_valid_o && freq_ready_i) begin
            freq_valid_o <= 1'b0;
            // no stale value after release
            freq_sample_o <= ~freq_sample_o;
        end else if (!freq_valid_o) begin
            freq_valid_o <= 1'b1;
            freq_sample_o <= tone;
        end
    end
endmodule

/* File: test/testbench.sv */
// Purpose: self-checking bench for the fsk receive slicer
// Assumes: 100 MHz clock, Avalon master tasks, transmitter model
// Notes: receiver stalls bit output 4 of every 32 cycles
`timescale 1ns/100ps
module testbench;
    import fsksl_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [AW-1:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, freq_ready_o, freq_valid_i, bit_data_o, bit_valid_o;
    logic bit_ready_i = 1'b0;
    logic signed [FW-1:0] freq_sample_i, avg_freq_o;
    logic signed [FW-1:0] centre = 16'sh0000;
    logic signed [FW-1:0] dev = 16'sh0000;
    logic sym = 1'b0;
    logic filter_skip_o, adc_tick_o, if_tick_o, slice_valid_o, got_bit;
    logic [31:0] rd;
    int bad_count = 0;
    int samples_checked = 0;
    int n_adc = 0;
    int n_if = 0;
    int cyc = 0;

    always #5 core_clk_i = ~core_clk_i;

    fsksl_top i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .freq_sample_i(freq_sample_i), .freq_valid_i(freq_valid_i),
        .freq_ready_o(freq_ready_o), .bit_data_o(bit_data_o), .bit_valid_o(bit_valid_o),
        .bit_ready_i(bit_ready_i), .filter_skip_o(filter_skip_o), .adc_tick_o(adc_tick_o),
        .if_tick_o(if_tick_o), .avg_freq_o(avg_freq_o), .slice_valid_o(slice_valid_o));

    fsksl_tx_model i_tx (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sym_i(sym),
        .centre_i(centre), .dev_i(dev), .freq_ready_i(freq_ready_o),
        .freq_sample_o(freq_sample_i), .freq_valid_o(freq_valid_i));

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        bit_ready_i <= (cyc[4:2] != 3'b000);
        n_adc <= n_adc + int'(adc_tick_o === 1'b1);
        n_if <= n_if + int'(if_tick_o === 1'b1);
        if (bit_valid_o === 1'b1 && bit_ready_i) begin
            got_bit <= bit_data_o;
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // held until waitrequest is sampled low, then an edge passes before the next
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("BAD waitrequest expected 0 seen %b", avs_waitrequest_o);
        end
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic send_bit(input logic b);
        int k;
        k = 0;
        sym <= b;
        for (int i = 0; i < 4000 && k < 8; i++) begin
            @(posedge core_clk_i);
            k += int'(freq_valid_i && freq_ready_o === 1'b1);
        end
        if (k < 8) begin
            bad_count++;
            $display("BAD takes expected 8 seen %0d", k);
        end
    endtask

    task automatic t_regs();
        bus(1'b0, ADDR_CONFIG_A, 32'h0);
        check("config_a", 32'h0008_0003, rd);
        bus(1'b0, ADDR_FREQ_CORR, 32'h0);
        check("freq_corr", 32'h0000_0050, rd);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", 32'h0000_0000, rd);
        bus(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("status", 32'h0000_0000, rd & 32'hFFFF_FFF7);
    endtask

    // if rate is a quarter of the adc rate, crystal over 8*(div+1)
    task automatic t_ticks();
        int a0;
        int i0;
        for (int d = 0; d < 4; d += 3) begin
            bus(1'b1, ADDR_CONFIG_A, 32'h0008_0000 | d);
            // snapshot instead of clearing: the counters have one writer only
            a0 = n_adc;
            i0 = n_if;
            repeat (256 * (d + 1)) @(posedge core_clk_i);
            check("adc_ticks", 1, (n_adc - a0 >= 127 && n_adc - a0 <= 129));
            check("if_ticks", 1, (n_if - i0 >= 31 && n_if - i0 <= 33));
        end
    endtask

    task automatic t_divcodes();
        logic [4:0] codes [7] = '{5'h18, 5'h0F, 5'h0B, 5'h05, 5'h02, 5'h01, 5'h00};
        foreach (codes[i]) begin
            bus(1'b1, ADDR_CONFIG_A, 32'h0008_0003 | (32'(codes[i]) << 4));
            bus(1'b0, ADDR_CONFIG_A, 32'h0);
            check("decimation_divider", 32'(codes[i]), 32'(rd[8:4]));
        end
    endtask

    task automatic t_slicer();
        bus(1'b1, ADDR_CONFIG_A, 32'h0008_000B);
        // the registered copy lands one edge after the bus returns
        @(posedge core_clk_i);
        check("filter_skip", 1, filter_skip_o);
        bus(1'b1, ADDR_FREQ_CORR, 32'h0000_0050);
        centre <= 16'sd500;
        dev <= 16'sd1000;
        send_bit(1'b0);
        send_bit(1'b1);
        check("early_valid", 0, slice_valid_o);
        for (int i = 0; i < 4; i++) send_bit(i[0]);
        check("slice_valid", 1, slice_valid_o);
        check("avg_freq", 32'h0000_01F4, 32'(avg_freq_o));
        bus(1'b0, ADDR_AVG_FREQ, 32'h0);
        check("avg_reg", 32'h0000_01F4, rd);
        repeat (3) send_bit(1'b1);
        repeat (20) @(posedge core_clk_i);
        check("bit_one", 1, got_bit);
        repeat (3) send_bit(1'b0);
        repeat (20) @(posedge core_clk_i);
        check("bit_zero", 0, got_bit);
    endtask

    task automatic t_small_dev();
        bus(1'b1, ADDR_FREQ_CORR, 32'h0000_0050);
        dev <= 16'sd20;
        for (int i = 0; i < 6; i++) send_bit(i[0]);
        check("no_transition", 0, slice_valid_o);
    endtask

    task automatic t_len_off();
        bus(1'b1, ADDR_FREQ_CORR, 32'h0000_0010);
        dev <= 16'sd200;
        // last tone lies below the learnt centre yet above the IF
        for (int i = 0; i < 6; i++) send_bit(!i[0]);
        repeat (20) @(posedge core_clk_i);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("level_off", 0, 32'(rd[19:4]));
        check("bit_above_if", 1, got_bit);
    endtask

    initial begin
        repeat (50000) @(posedge core_clk_i);
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_regs();
        t_ticks();
        t_divcodes();
        t_slicer();
        t_small_dev();
        t_len_off();
        finish_test();
    end
endmodule
